// ===== hdl/gpm_pin_mux.sv
// Pin function mux for three 8-bit general purpose ports
`timescale 1ns/100ps
`include "gpm_defs.svh"

// Summary of operation
// - Every pin has its own 4-bit mode code selecting its behaviour.
// - Code 0x0 is analog; digital off, input bit reads 1.
// - Code 0x4 is floating input, driver off.
// - Code 0x8 is input with pull; output bit picks up or down.
// - Codes 0x1/0x5 drive push-pull/open-drain from the output bit.
// - Codes 0x9/0xD drive push-pull/open-drain from the peripheral.
// - Open-drain modes have no internal pull-up.
// - Extra registers pick the peripheral when two can drive a pin.
// - Enabled timer 2 channel outranks the serial controller on a shared pin.
// - Timer 2 route bits 4..7 map channels to port A or port B pins.
// - Serial controller mode decides how its pins are used.
// - PA4/PA5 carry packet trace or cpu trace by software choice.
// - Alternate mode without a peripheral drives 0.
// - Forced functions apply from reset over mode codes until released.
// - Forced: PA7 regulator open-drain, PC0/PC3 pulled inputs, PC2 push-pull.
// - Forced PC4 is pulled mode-select or debugger bidirectional data.
// - Debug starts in JTAG mode; only the tool switches it.
// - Clearing regulator enable bit returns PA7 to normal use.
// - Setting debug disable returns PC0, PC2, PC3, PC4 to normal use.
// - Setting debug disable is ignored while debug port is active.
// - Debugger active during reset regains pins and sets forced flag.
// - Debug port is active exactly when the power-up request is set.
// - Low config holds pins 3..0, high config pins 7..4.
// - Full reset: floating inputs, regulator enable set, debug disable cleared.
module gpm_pin_mux #(
   parameter int NPINS = 24
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register port
   input wire logic [`GPM_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Pins: index 0..7 port A, 8..15 port B, 16..23 port C
   input wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe,
   output logic [NPINS-1:0] pin_pull_up,
   output logic [NPINS-1:0] pin_pull_down,
   output logic [NPINS-1:0] pin_analog,
   // Peripheral sources
   input wire logic [3:0] timer2_chan_out,
   input wire logic [NPINS-1:0] serial_ctrl_out,
   input wire logic [NPINS-1:0] serial_ctrl_out_valid,
   input wire logic pkt_trace_frame,
   input wire logic pkt_trace_serial,
   input wire logic cpu_trace_bit2,
   input wire logic cpu_trace_bit3,
   input wire logic reg_en_signal,
   // Debug port side
   input wire logic debugger_powerup_request,
   input wire logic debug_serial_wire_mode,
   input wire logic debug_data_out,
   input wire logic debug_swdio_out,
   input wire logic debug_swdio_oe,
   input wire logic chip_in_reset,
   output logic debug_reset_in,
   output logic debug_data_in,
   output logic debug_mode_select,
   // Synchronised pin levels to peripherals
   output logic [NPINS-1:0] periph_in
);

   localparam int PA7 = 7;
   localparam int PC0 = 16;
   localparam int PC2 = 18;
   localparam int PC3 = 19;
   localparam int PC4 = 20;

   logic [31:0] pin_mode_config [0:5];
   logic [7:0] output_value_reg [0:2];
   logic [NPINS-1:0] input_value_reg;
   logic ext_regulator_enable_bit;
   logic debug_pins_disable;
   logic debug_forced_flag;
   logic [7:0] timer2_route_option;
   logic [3:0] timer2_channel_enable;
   logic trace_sel_cpu;
   logic debug_active;
   logic [NPINS-1:0] next_out;
   logic [NPINS-1:0] next_oe;
   logic [NPINS-1:0] next_pu;
   logic [NPINS-1:0] next_pd;
   logic [NPINS-1:0] next_an;
   logic [NPINS-1:0] next_in;
   logic [NPINS-1:0] alt_src;
   logic [NPINS-1:0] alt_has;
   gpm_pkg::gpm_pull_t next_pull [NPINS];
   logic [31:0] next_rdata;

   assign debug_active = debugger_powerup_request;

   // Configuration registers
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 6; i++) begin
            pin_mode_config[i] <= {16'h0000, `GPM_CFG_RESET};
         end
      end else if (clk_en && reg_wr && reg_addr <= `GPM_OFS_PC_CFGH) begin
         // Upper half is not stored and reads back as zero
         pin_mode_config[reg_addr[2:0]] <= {16'h0000, reg_wdata[15:0]};
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 3; i++) begin
            output_value_reg[i] <= `GPM_OUT_RESET;
         end
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `GPM_OFS_PA_OUT: output_value_reg[0] <= reg_wdata[7:0];
            `GPM_OFS_PB_OUT: output_value_reg[1] <= reg_wdata[7:0];
            `GPM_OFS_PC_OUT: output_value_reg[2] <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Peripheral routing selections
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer2_route_option <= 8'h00;
         timer2_channel_enable <= 4'h0;
         trace_sel_cpu <= 1'b0;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `GPM_OFS_T2_OPT: timer2_route_option <= reg_wdata[7:0];
            `GPM_OFS_T2_ENA: timer2_channel_enable <= reg_wdata[3:0];
            `GPM_OFS_TRACE_SEL: trace_sel_cpu <= reg_wdata[0];
            default: ;
         endcase
      end
   end

   // Debug configuration; reset restores forced functions
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_regulator_enable_bit <= 1'b1;
         debug_pins_disable <= 1'b0;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == `GPM_OFS_DBGCFG) begin
            ext_regulator_enable_bit <= reg_wdata[`GPM_BIT_EXTREGEN];
         end
         // A reclaiming debugger outranks a software write in the same cycle
         if (chip_in_reset && debug_active) begin
            debug_pins_disable <= 1'b0;
         end else if (reg_wr && reg_addr == `GPM_OFS_DBGCFG) begin
            if (!reg_wdata[`GPM_BIT_DEBUGDIS]) begin
               debug_pins_disable <= 1'b0;
            end else if (!debug_active) begin
               debug_pins_disable <= 1'b1;
            end
         end
      end
   end

   // Forced flag: set by debugger reclaim, cleared by full reset only
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         debug_forced_flag <= 1'b0;
      end else if (clk_en && chip_in_reset && debug_active && debug_pins_disable) begin
         debug_forced_flag <= 1'b1;
      end
   end

   // Alternate output sources
   always_comb begin
      alt_src = serial_ctrl_out;
      alt_has = serial_ctrl_out_valid;
      alt_src[4] = trace_sel_cpu ? cpu_trace_bit2 : pkt_trace_frame;
      alt_src[5] = trace_sel_cpu ? cpu_trace_bit3 : pkt_trace_serial;
      alt_has[4] = 1'b1;
      alt_has[5] = 1'b1;
      // Timer channel wins over serial controller once enabled
      for (int c = 0; c < 4; c++) begin
         if (timer2_channel_enable[c]) begin
            if (timer2_route_option[`GPM_T2_OPT_LSB + c]) begin
               alt_src[9 + c] = timer2_chan_out[c];
               alt_has[9 + c] = 1'b1;
            end else begin
               case (c)
                  0: begin alt_src[0] = timer2_chan_out[0]; alt_has[0] = 1'b1; end
                  1: begin alt_src[3] = timer2_chan_out[1]; alt_has[3] = 1'b1; end
                  2: begin alt_src[1] = timer2_chan_out[2]; alt_has[1] = 1'b1; end
                  default: begin alt_src[2] = timer2_chan_out[3]; alt_has[2] = 1'b1; end
               endcase
            end
         end
      end
   end

   // Per-pin mode decode
   always_comb begin
      logic [3:0] code;
      logic ov;
      logic drv;
      code = 4'h0;
      ov = 1'b0;
      drv = 1'b0;
      for (int p = 0; p < NPINS; p++) begin
         code = pin_mode_config[p / 4][4 * (p % 4) +: 4];
         ov = output_value_reg[p / 8][p % 8];
         drv = alt_has[p] ? alt_src[p] : 1'b0;
         next_out[p] = 1'b0;
         next_oe[p] = 1'b0;
         next_pull[p] = gpm_pkg::gpm_pull_none;
         next_an[p] = 1'b0;
         next_in[p] = pin_in[p];
         case (code)
            `GPM_MODE_ANALOG: begin
               next_an[p] = 1'b1;
               next_in[p] = 1'b1;
            end
            `GPM_MODE_IN_FLOAT: ;
            `GPM_MODE_IN_PULL: begin
               next_pull[p] = ov ? gpm_pkg::gpm_pull_up : gpm_pkg::gpm_pull_down;
            end
            `GPM_MODE_OUT_PP: begin
               next_out[p] = ov;
               next_oe[p] = 1'b1;
            end
            `GPM_MODE_OUT_OD: begin
               next_oe[p] = !ov;
            end
            `GPM_MODE_ALT_PP: begin
               next_out[p] = drv;
               next_oe[p] = 1'b1;
            end
            `GPM_MODE_ALT_OD: begin
               next_oe[p] = !drv;
            end
            default: ; // Undefined codes behave as floating inputs
         endcase
      end
      // Forced functions override the codes
      // While forced, PA7 only sinks; any pull-up for it sits on the board
      if (ext_regulator_enable_bit) begin
         next_out[PA7] = 1'b0;
         next_oe[PA7] = !reg_en_signal;
         next_pull[PA7] = gpm_pkg::gpm_pull_none;
         next_an[PA7] = 1'b0;
         next_in[PA7] = pin_in[PA7];
      end
      if (!debug_pins_disable) begin
         for (int k = 0; k < 4; k++) begin
            next_pull[PC0 + k] = gpm_pkg::gpm_pull_none;
            next_an[PC0 + k] = 1'b0;
            next_out[PC0 + k] = 1'b0;
            next_oe[PC0 + k] = 1'b0;
            next_in[PC0 + k] = pin_in[PC0 + k];
         end
         next_pull[PC0] = gpm_pkg::gpm_pull_up;
         next_pull[PC3] = gpm_pkg::gpm_pull_up;
         next_out[PC2] = debug_data_out;
         next_oe[PC2] = 1'b1;
         next_in[PC2] = pin_in[PC2];
         next_an[PC2] = 1'b0;
         // Tool owns the mode; reset state of that input is JTAG
         if (debug_serial_wire_mode) begin
            next_out[PC4] = debug_swdio_out;
            next_oe[PC4] = debug_swdio_oe;
            next_in[PC4] = pin_in[PC4];
            next_an[PC4] = 1'b0;
         end else begin
            next_pull[PC4] = gpm_pkg::gpm_pull_up;
            next_in[PC4] = pin_in[PC4];
            next_an[PC4] = 1'b0;
         end
      end
   end

   // One pull choice per pin keeps up and down from ever meeting
   always_comb begin
      for (int p = 0; p < NPINS; p++) begin
         case (next_pull[p])
            gpm_pkg::gpm_pull_up: begin
               next_pu[p] = 1'b1;
               next_pd[p] = 1'b0;
            end
            gpm_pkg::gpm_pull_down: begin
               next_pu[p] = 1'b0;
               next_pd[p] = 1'b1;
            end
            default: begin
               next_pu[p] = 1'b0;
               next_pd[p] = 1'b0;
            end
         endcase
      end
   end

   // Pin drive and captured input
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_out <= '0;
         pin_oe <= '0;
         pin_pull_up <= '0;
         pin_pull_down <= '0;
         pin_analog <= '0;
         input_value_reg <= '0;
         periph_in <= '0;
      end else if (clk_en) begin
         pin_out <= next_out;
         pin_oe <= next_oe;
         pin_pull_up <= next_pu;
         pin_pull_down <= next_pd;
         pin_analog <= next_an;
         input_value_reg <= next_in;
         periph_in <= next_in;
      end
   end

   // Debug port inputs reach the debugger only while forced
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         debug_reset_in <= 1'b1;
         debug_data_in <= 1'b1;
         debug_mode_select <= 1'b1;
      end else if (clk_en) begin
         debug_reset_in <= debug_pins_disable ? 1'b1 : pin_in[PC0];
         debug_data_in <= debug_pins_disable ? 1'b1 : pin_in[PC3];
         debug_mode_select <= debug_pins_disable ? 1'b1 : pin_in[PC4];
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (reg_addr)
         `GPM_OFS_PA_CFGL, `GPM_OFS_PA_CFGH, `GPM_OFS_PB_CFGL,
         `GPM_OFS_PB_CFGH, `GPM_OFS_PC_CFGL, `GPM_OFS_PC_CFGH:
            next_rdata = pin_mode_config[reg_addr[2:0]];
         `GPM_OFS_PA_OUT: next_rdata = {24'h00_0000, output_value_reg[0]};
         `GPM_OFS_PB_OUT: next_rdata = {24'h00_0000, output_value_reg[1]};
         `GPM_OFS_PC_OUT: next_rdata = {24'h00_0000, output_value_reg[2]};
         `GPM_OFS_PA_IN: next_rdata = {24'h00_0000, input_value_reg[7:0]};
         `GPM_OFS_PB_IN: next_rdata = {24'h00_0000, input_value_reg[15:8]};
         `GPM_OFS_PC_IN: next_rdata = {24'h00_0000, input_value_reg[23:16]};
         `GPM_OFS_DBGCFG: begin
            next_rdata[`GPM_BIT_EXTREGEN] = ext_regulator_enable_bit;
            next_rdata[`GPM_BIT_DEBUGDIS] = debug_pins_disable;
         end
         `GPM_OFS_DBGSTAT: next_rdata[`GPM_BIT_FORCEDBG] = debug_forced_flag;
         `GPM_OFS_T2_OPT: next_rdata = {24'h00_0000, timer2_route_option};
         `GPM_OFS_T2_ENA: next_rdata = {28'h000_0000, timer2_channel_enable};
         `GPM_OFS_TRACE_SEL: next_rdata = {31'h0000_0000, trace_sel_cpu};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Data only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      end
   end

endmodule // gpm_pin_mux

// ===== hdl/gpm_defs.svh
// Register offsets, field positions, reset values and mode codes for the pin function mux
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH
`define GPM_ADDR_W 6
`define GPM_OFS_PA_CFGL 6'h00
`define GPM_OFS_PA_CFGH 6'h01
`define GPM_OFS_PB_CFGL 6'h02
`define GPM_OFS_PB_CFGH 6'h03
`define GPM_OFS_PC_CFGL 6'h04
`define GPM_OFS_PC_CFGH 6'h05
`define GPM_OFS_PA_OUT 6'h06
`define GPM_OFS_PB_OUT 6'h07
`define GPM_OFS_PC_OUT 6'h08
`define GPM_OFS_PA_IN 6'h09
`define GPM_OFS_PB_IN 6'h0A
`define GPM_OFS_PC_IN 6'h0B
`define GPM_OFS_DBGCFG 6'h0C
`define GPM_OFS_DBGSTAT 6'h0D
`define GPM_OFS_T2_OPT 6'h0E
`define GPM_OFS_T2_ENA 6'h0F
`define GPM_OFS_TRACE_SEL 6'h10
`define GPM_CFG_RESET 16'h4444
`define GPM_OUT_RESET 8'h00
`define GPM_BIT_EXTREGEN 5
`define GPM_BIT_DEBUGDIS 4
`define GPM_BIT_FORCEDBG 3
`define GPM_T2_OPT_LSB 4
`define GPM_MODE_ANALOG 4'h0
`define GPM_MODE_IN_FLOAT 4'h4
`define GPM_MODE_IN_PULL 4'h8
`define GPM_MODE_OUT_PP 4'h1
`define GPM_MODE_OUT_OD 4'h5
`define GPM_MODE_ALT_PP 4'h9
`define GPM_MODE_ALT_OD 4'hD
`endif

// ===== hdl/gpm_pkg.sv
// Types for the pin function mux
package gpm_pkg;
   typedef enum logic [1:0] {
      gpm_pull_none,
      gpm_pull_up,
      gpm_pull_down
   } gpm_pull_t;
endpackage

// ===== bench/gpm_pin_mux_checker.sv
// Port checker for the pin function mux
`timescale 1ns/100ps
`include "gpm_defs.svh"
module gpm_chk #(
   parameter int NPINS = 24
) (
   // Clock, reset, register port
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [`GPM_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Pins
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NPINS-1:0] pin_pull_up,
   input wire logic [NPINS-1:0] pin_pull_down,
   input wire logic [NPINS-1:0] pin_analog,
   // Sources and debug side
   input wire logic reg_en_signal,
   input wire logic debugger_powerup_request,
   input wire logic debug_serial_wire_mode,
   input wire logic debug_data_out,
   input wire logic debug_swdio_out,
   input wire logic debug_swdio_oe,
   input wire logic chip_in_reset,
   input wire logic debug_reset_in,
   input wire logic debug_data_in,
   input wire logic debug_mode_select
);
   logic up;
   logic ext_m;
   logic dis_m;
   logic cfg_wr;
   assign cfg_wr = clk_en && reg_wr && reg_addr == `GPM_OFS_DBGCFG;
   // Pins lag one edge, so checks start after the first edge out of reset
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) up <= 1'b0;
      else up <= 1'b1;
   end
   // Debug config mirror, kept from the bus so no internal probes are needed
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) ext_m <= 1'b1;
      else if (cfg_wr) ext_m <= reg_wdata[`GPM_BIT_EXTREGEN];
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) dis_m <= 1'b0;
      else if (clk_en && chip_in_reset && debugger_powerup_request) dis_m <= 1'b0;
      else if (cfg_wr) dis_m <= reg_wdata[`GPM_BIT_DEBUGDIS] && (dis_m || !debugger_powerup_request);
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_cfg_rd;
      reg_rd && reg_addr == `GPM_OFS_DBGCFG;
   endsequence
   sequence s_forced;
      up && !$past(dis_m);
   endsequence
   a_cfg_readback: assert property (s_cfg_rd |=> reg_rdata[5:4] == {$past(ext_m), $past(dis_m)})
      else $error("debug config readback wrong");
   a_regen_forced: assert property (up && $past(ext_m) |-> pin_oe[7] == !$past(reg_en_signal) && !pin_out[7])
      else $error("regulator pin not open drain");
   a_dbg_drive: assert property (s_forced |-> pin_oe[18] && pin_out[18] == $past(debug_data_out))
      else $error("debug data out not driven");
   a_jtag_pulls: assert property (s_forced ##0 !$past(debug_serial_wire_mode) |->
      pin_pull_up[16] && pin_pull_up[19] && pin_pull_up[20] && !pin_oe[16] && !pin_oe[20])
      else $error("debug inputs not pulled up");
   a_swd_follow: assert property (s_forced ##0 $past(debug_serial_wire_mode) |-> pin_oe[20] == $past(debug_swdio_oe)
      && (!pin_oe[20] || pin_out[20] == $past(debug_swdio_out)))
      else $error("serial wire data pin wrong");
   a_released_high: assert property (up && $past(dis_m, 2) && $past(dis_m) |->
      debug_reset_in && debug_data_in && debug_mode_select)
      else $error("released debug inputs not high");
   a_pull_excl: assert property ((pin_pull_up & pin_pull_down) == '0)
      else $error("pull up and down together");
   a_analog_quiet: assert property ((pin_analog & (pin_oe | pin_pull_up | pin_pull_down)) == '0)
      else $error("analog pin not quiet");
endmodule // gpm_chk
bind gpm_pin_mux gpm_chk #(.NPINS(NPINS)) gpm_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
   .pin_analog(pin_analog), .reg_en_signal(reg_en_signal), .debugger_powerup_request(debugger_powerup_request),
   .debug_serial_wire_mode(debug_serial_wire_mode), .debug_data_out(debug_data_out),
   .debug_swdio_out(debug_swdio_out), .debug_swdio_oe(debug_swdio_oe), .chip_in_reset(chip_in_reset),
   .debug_reset_in(debug_reset_in), .debug_data_in(debug_data_in), .debug_mode_select(debug_mode_select));

// ===== bench/gpm_far_side.sv
// Far side model: pad loads, external drivers and debug tool mode
`timescale 1ns/100ps
module gpm_far_side (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Pad side of the design
   input wire logic [23:0] pin_out,
   input wire logic [23:0] pin_oe,
   input wire logic [23:0] pin_pull_up,
   input wire logic [23:0] pin_pull_down,
   output logic [23:0] pin_in,
   // External drivers and tool request
   input wire logic [23:0] ext_en,
   input wire logic [23:0] ext_val,
   input wire logic tool_sw,
   output logic debug_serial_wire_mode
);
   logic [23:0] flt;
   // Undriven unpulled lines wander, so nothing can rely on them
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) flt <= 24'h5A_5A5A;
      else flt <= ~flt;
   end
   // No pull-up on released open-drain lines unless one is fitted outside
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
      (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & flt)));
   // Tool comes up in JTAG after reset; only it may change the mode
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) debug_serial_wire_mode <= 1'b0;
      else debug_serial_wire_mode <= tool_sw;
   end
endmodule // gpm_far_side

// ===== bench/gpm_pin_mux_test.sv
// Self-checking bench for the pin function mux
`timescale 1ns/100ps
`include "gpm_defs.svh"
module gpm_pin_mux_test;
   logic ref_clk, sys_rst, wr_s, rd_s, pf, ps, tb2, tb3, reg_en, pwr, tool_sw, sw_mode, ce;
   logic dd_out, swd_out, swd_oe, chip_rst, dbg_rst, dbg_din, dbg_ms;
   logic [5:0] addr;
   logic [31:0] wd, rdat;
   logic [23:0] pin_in, po, oe, pu, pd, pa, ser_out, ser_vld, ext_en, ext_val, pif;
   logic [3:0] t2_out;
   int err_count, cmp_count;
   gpm_pin_mux gpm_pin_mux_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce), .reg_addr(addr),
      .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .pin_in(pin_in), .pin_out(po),
      .pin_oe(oe), .pin_pull_up(pu), .pin_pull_down(pd), .pin_analog(pa), .timer2_chan_out(t2_out),
      .serial_ctrl_out(ser_out), .serial_ctrl_out_valid(ser_vld), .pkt_trace_frame(pf), .pkt_trace_serial(ps),
      .cpu_trace_bit2(tb2), .cpu_trace_bit3(tb3), .reg_en_signal(reg_en), .debugger_powerup_request(pwr),
      .debug_serial_wire_mode(sw_mode), .debug_data_out(dd_out), .debug_swdio_out(swd_out),
      .debug_swdio_oe(swd_oe), .chip_in_reset(chip_rst), .debug_reset_in(dbg_rst), .debug_data_in(dbg_din),
      .debug_mode_select(dbg_ms), .periph_in(pif));
   gpm_far_side gpm_far_side_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_out(po), .pin_oe(oe),
      .pin_pull_up(pu), .pin_pull_down(pd), .pin_in(pin_in), .ext_en(ext_en), .ext_val(ext_val),
      .tool_sw(tool_sw), .debug_serial_wire_mode(sw_mode));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wr_s <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge ref_clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1 d = rdat;
   endtask
   // Packs analog, pulls, enable and driven level of one pin
   function automatic logic [4:0] pgot(input int i);
      pgot = {pa[i], pu[i], pd[i], oe[i], oe[i] & po[i]};
   endfunction
   function automatic logic [4:0] pexp(input logic [3:0] c, input logic ob, input logic alt);
      case (c)
         4'h0: pexp = 5'h10;
         4'h8: pexp = {1'b0, ob, !ob, 2'h0};
         4'h1: pexp = {4'h1, ob};
         4'h5: pexp = {3'h0, !ob, 1'b0};
         4'h9: pexp = {4'h1, alt};
         4'hD: pexp = {3'h0, !alt, 1'b0};
         default: pexp = 5'h00;
      endcase
   endfunction
   task automatic t_reset;
      logic [31:0] d;
      for (int a = 0; a < 6; a++) begin
         rd(6'(a), d);
         chk(d, 32'h0000_4444);
      end
      rd(`GPM_OFS_DBGCFG, d);
      chk(d & 32'h0000_0030, 32'h0000_0020);
      rd(`GPM_OFS_DBGSTAT, d);
      chk(d & 32'h0000_0008, 32'h0000_0000);
      wr(6'h3F, 32'hFFFF_FFFF);
      rd(6'h3F, d);
      chk(d, 32'h0000_0000);
      chk(32'({pgot(0), pgot(18)}), 32'({5'h00, 4'h1, dd_out}));
   endtask
   task automatic t_modes;
      logic [31:0] d;
      logic [4:0] pe;
      logic [3:0] codes [7] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hD};
      for (int k = 0; k < 14; k++) begin
         wr(`GPM_OFS_PB_OUT, {24'h00_0000, {8{k[0]}}});
         wr(`GPM_OFS_PB_CFGH, (32'h0000_4444 & ~(32'h0000_000F << 4 * (k % 4))) | (32'(codes[k / 2]) << 4 * (k % 4)));
         settle(3);
         pe = pexp(codes[k / 2], k[0], ser_vld[12 + k % 4] & ser_out[12 + k % 4]);
         chk(32'(pgot(12 + k % 4)), 32'(pe));
         rd(`GPM_OFS_PB_IN, d);
         chk(32'(d[4 + k % 4]), 32'(pe[0] | (codes[k / 2] == 4'h0)));
         chk(32'(pif[12 + k % 4]), 32'(pe[0] | (codes[k / 2] == 4'h0)));
      end
   endtask
   task automatic t_alt;
      logic [23:0] e;
      logic [3:0] ena;
      int pa_pin [4] = '{0, 3, 1, 2};
      wr(`GPM_OFS_PA_CFGL, 32'h0000_9999);
      wr(`GPM_OFS_PB_CFGL, 32'h0000_9999);
      wr(`GPM_OFS_PB_CFGH, 32'h0000_4449);
      for (int k = 0; k < 16; k++) begin
         ena = 4'(k) ^ 4'h5;
         @(posedge ref_clk);
         t2_out <= 4'(k * 3);
         wr(`GPM_OFS_T2_OPT, 32'(k) << `GPM_T2_OPT_LSB);
         wr(`GPM_OFS_T2_ENA, 32'(ena));
         settle(2);
         e = ser_out;
         for (int c = 0; c < 4; c++) begin
            if (ena[c]) e[k[c] ? 9 + c : pa_pin[c]] = t2_out[c];
         end
         chk(32'({po[12:9], po[3:0]}), 32'({e[12:9], e[3:0]}));
         chk(32'({oe[12:9], oe[3:0]}), 32'h0000_00FF);
      end
   endtask
   task automatic t_trace;
      wr(`GPM_OFS_PA_CFGH, 32'h0000_1099);
      wr(`GPM_OFS_PA_OUT, 32'h0000_0080);
      for (int s = 0; s < 2; s++) begin
         @(posedge ref_clk);
         {pf, ps, tb2, tb3, reg_en} <= {s[0], s[0], !s[0], !s[0], s[0]};
         wr(`GPM_OFS_TRACE_SEL, 32'(s));
         settle(2);
         chk(32'(po[5:4]), s ? 32'({tb3, tb2}) : 32'({ps, pf}));
         chk(32'(oe[7]), 32'(!reg_en));
      end
      wr(`GPM_OFS_DBGCFG, 32'h0000_0000);
      settle(2);
      chk(32'(pgot(7)), 32'h0000_0003);
   endtask
   task automatic t_debug;
      logic [31:0] d;
      @(posedge ref_clk);
      {pwr, tool_sw, swd_oe, swd_out} <= 4'hE;
      wr(`GPM_OFS_DBGCFG, 32'h0000_0010);
      rd(`GPM_OFS_DBGCFG, d);
      chk(d & 32'h0000_0010, 32'h0000_0000);
      chk(32'(pgot(20)), 32'h0000_0002);
      @(posedge ref_clk);
      {pwr, dd_out} <= 2'h1;
      wr(`GPM_OFS_DBGCFG, 32'h0000_0010);
      settle(3);
      chk(32'({pgot(18), dbg_rst, dbg_din, dbg_ms}), 32'h0000_0007);
      @(posedge ref_clk);
      {chip_rst, pwr} <= 2'h3;
      repeat (2) @(posedge ref_clk);
      chip_rst <= 1'b0;
      settle(3);
      rd(`GPM_OFS_DBGSTAT, d);
      chk(d & 32'h0000_0008, 32'h0000_0008);
      chk(32'({pgot(18), dbg_rst, dbg_din}), 32'h0000_000C);
   endtask
   // A write while the enable is low must leave the register untouched
   task automatic t_freeze;
      logic [31:0] d;
      @(posedge ref_clk);
      ce <= 1'b0;
      wr(`GPM_OFS_PA_OUT, 32'h0000_00FF);
      @(posedge ref_clk);
      ce <= 1'b1;
      rd(`GPM_OFS_PA_OUT, d);
      chk(d, 32'h0000_0080);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100_000;
      err_count++;
      end_of_test();
   end
   initial begin
      {sys_rst, wr_s, rd_s, addr, wd, t2_out} = {1'b1, 44'h0};
      ce = 1'b1;
      {pf, ps, tb2, tb3, reg_en, pwr, tool_sw, dd_out, swd_out, swd_oe, chip_rst} = 11'h010;
      {ser_out, ser_vld, ext_en, ext_val} = {24'hA5_5A5A, 24'h00_1FFF, 24'h09_FF00, 24'h00_0000};
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_modes();
      t_alt();
      t_trace();
      t_debug();
      t_freeze();
      @(posedge ref_clk);
      {sys_rst, pwr, tool_sw} <= 3'h4;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      end_of_test();
   end
endmodule // gpm_pin_mux_test
